/* rtl/bepd_beam_eval.sv */
// Beam evaluation and cyclic process data assembly of a light curtain
// receiver, with the parameter records read by index and all but the cycle time written.
// Assumes raw beams, area, output and status words come from logic on
// this clock; the operating keys come from pins.
`timescale 1ns/10ps
`default_nettype none
`include "bepd_map.svh"

module bepd_beam_eval
   import bepd_pkg::*;
#(
   parameter int BEAMS      = 256,
   parameter int KEYS       = 4,
   parameter int CYCLE_CLKS = `BEPD_CYCLE_TIME_US * `BEPD_CLOCK_MHZ,
   parameter int MS_CLKS    = `BEPD_MS_US * `BEPD_CLOCK_MHZ
)
(
   input  wire logic             clock,         // System clock, 50 MHz
   input  wire logic             rst_n,         // Synchronous reset, active low
   input  wire logic [BEAMS-1:0] beamRaw,       // Raw beams, 1 = blocked
   input  wire logic [31:0]      areaState,     // Area switching states
   input  wire logic [15:0]      mappedOutputs, // Outputs mapped to areas
   input  wire logic [15:0]      statusWord,    // Sensor status word
   input  wire logic [KEYS-1:0]  keyRaw,        // Panel keys from pins
   input  wire bepd_par_cmd_type parCmd,        // Parameter request
   output bepd_par_rsp_type      parRsp,        // Parameter answer
   output logic [KEYS-1:0]       keyOut,        // Keys after lock
   output logic [255:0]          pdData,        // Process data, byte 0 on top
   output logic [5:0]            pdLength,      // Valid bytes in pdData
   output logic                  pdUpdate       // New process data pulse
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [15:0]      cycleCnt;
      logic             pass;
      logic             passD;
      logic             asmGo;
      logic [15:0]      msCnt;
      logic [15:0]      holdCnt;
      logic [BEAMS-1:0] acc;
      logic [BEAMS-1:0] held;
      logic [127:0]     slots;
      logic [7:0]       depth;
      logic [15:0]      holdMs;
      logic             lock;
      logic [KEYS-1:0]  keyMeta;
      logic [KEYS-1:0]  keySync;
      logic [KEYS-1:0]  keyOut;
      bepd_par_rsp_type rsp;
      bepd_asm_type     asmState;
      logic [4:0]       slotIdx;
      logic [5:0]       bytePtr;
      logic [7:0]       remain;
      logic             isStream;
      logic [15:0]      word;
      logic [15:0]      cursor;
      logic [255:0]     shadow;
      logic [255:0]     pdData;
      logic [5:0]       pdLength;
      logic             pdUpdate;
   } bepd_eval_state_type;

   bepd_eval_state_type s;
   bepd_eval_state_type next_s;
   logic [BEAMS-1:0]    filtered;

   localparam logic [15:0] CYCLE_LAST = 16'(CYCLE_CLKS - 1);
   localparam logic [15:0] MS_LAST    = 16'(MS_CLKS - 1);
   localparam logic [15:0] BEAM_COUNT = 16'(BEAMS);
   localparam logic [5:0]  PD_LAST    = 6'(`BEPD_PD_BYTES - 1);

   // Reset record: slot one last blocked beam, all others idle
   localparam logic [127:0] SLOT_RESET =
      {`BEPD_SLOT_ONE_RESET, {(`BEPD_SLOTS - 1){`BEPD_SLOT_OTHER_RESET}}};

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Codes accepted into a slot
   function automatic logic code_ok(input logic [7:0] code);
      code_ok = (code <= `BEPD_CODE_STREAM_MAX) ||
                (code >= `BEPD_CODE_FIRST_BLOCKED && code <= `BEPD_CODE_CLEAR_TOTAL) ||
                (code >= `BEPD_CODE_AREAS_LOW && code <= `BEPD_CODE_OUTPUTS) ||
                (code == `BEPD_CODE_STATUS);
   endfunction

   // ----------------------------------------------------------------------
   // Per-beam filters
   // ----------------------------------------------------------------------
   // One filter per beam, all paced by the same registered pass pulse
   for (genvar b = 0; b < BEAMS; b++)
   begin : g_filter
      bepd_beam_filter u_filter
      (
         .clock    (clock),
         .rst_n    (rst_n),
         .pass     (s.pass),
         .raw      (beamRaw[b]),
         .depth    (s.depth),
         .filtered (filtered[b])
      );
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      logic [15:0]      firstBlocked;
      logic [15:0]      firstClear;
      logic [15:0]      lastBlocked;
      logic [15:0]      lastClear;
      logic [15:0]      blockedTotal;
      logic [BEAMS-1:0] accNew;
      logic [127:0]     rec;
      logic [7:0]       code;
      logic [7:0]       byteVal;
      int               idx;

      firstBlocked = 16'h0000;
      firstClear   = 16'h0000;
      lastBlocked  = 16'h0000;
      lastClear    = 16'h0000;
      blockedTotal = 16'h0000;
      accNew       = '0;
      rec          = '0;
      code         = 8'h00;
      byteVal      = 8'h00;
      idx          = 0;
      next_s       = s;
      next_s.pdUpdate = 1'b0;
      // Measurement cycle timer; the pass pulse paces filters and output
      next_s.pass = 1'b0;
      if (s.cycleCnt == CYCLE_LAST)
      begin
         next_s.cycleCnt = 16'h0000;
         next_s.pass     = 1'b1;
      end
      else
         next_s.cycleCnt = s.cycleCnt + 16'h0001;
      next_s.passD = s.pass;
      next_s.asmGo = s.passD;
      // Hold window: blocked beams are ORed in until the window closes
      accNew = s.passD ? (s.acc | filtered) : s.acc;
      next_s.acc = accNew;
      if (s.holdMs == 16'h0000)
      begin
         next_s.holdCnt = 16'h0000;
         next_s.msCnt   = 16'h0000;
         next_s.acc     = '0;
         if (s.passD)
            next_s.held = filtered;
      end
      else
      begin
         next_s.msCnt = (s.msCnt == MS_LAST) ? 16'h0000 : s.msCnt + 16'h0001;
         if (s.msCnt == MS_LAST)
         begin
            if (s.holdCnt + 16'h0001 >= s.holdMs)
            begin
               next_s.held    = accNew;
               next_s.acc     = '0;
               next_s.holdCnt = 16'h0000;
            end
            else
               next_s.holdCnt = s.holdCnt + 16'h0001;
         end
      end

      // Beam figures over the held image, beams numbered from one
      for (int i = 0; i < BEAMS; i++)
      begin
         if (s.held[i])
         begin
            if (firstBlocked == 16'h0000)
               firstBlocked = 16'(i + 1);
            lastBlocked  = 16'(i + 1);
            blockedTotal = blockedTotal + 16'h0001;
         end
         else
         begin
            if (firstClear == 16'h0000)
               firstClear = 16'(i + 1);
            lastClear = 16'(i + 1);
         end
      end

      // Key synchroniser and lock
      next_s.keyMeta = keyRaw;
      next_s.keySync = s.keyMeta;
      next_s.keyOut  = s.lock ? '0 : s.keySync;

      // Parameter access by index; a write wins over a read
      next_s.rsp = '0;
      if (parCmd.write)
      begin
         next_s.rsp.ack = 1'b1;
         unique case (parCmd.index)
            `BEPD_IDX_SLOT_RECORD:
            begin
               // Whole record only; a bad code leaves its slot as it was
               for (int k = 0; k < `BEPD_SLOTS; k++)
               begin
                  if (code_ok(parCmd.data[8*k +: 8]))
                     rec[8*k +: 8] = parCmd.data[8*k +: 8];
                  else
                     rec[8*k +: 8] = s.slots[8*k +: 8];
               end
               next_s.slots = rec;
            end
            `BEPD_IDX_EXTENDED:
            begin
               if (parCmd.data[`BEPD_DEPTH_POS +: 8] != 8'h00)
                  next_s.depth = parCmd.data[`BEPD_DEPTH_POS +: 8];
               next_s.holdMs  = parCmd.data[`BEPD_HOLD_POS +: 16];
               next_s.holdCnt = 16'h0000;
            end
            `BEPD_IDX_PANEL_LOCK:
               next_s.lock = parCmd.data[0];
            default:
               next_s.rsp.error = 1'b1;   // Unknown or read-only index
         endcase
      end
      else if (parCmd.read)
      begin
         next_s.rsp.ack = 1'b1;
         unique case (parCmd.index)
            `BEPD_IDX_CYCLE_TIME:
               next_s.rsp.rdata = 128'(16'(`BEPD_CYCLE_TIME_US));
            `BEPD_IDX_SLOT_RECORD:
               next_s.rsp.rdata = s.slots;
            `BEPD_IDX_EXTENDED:
               next_s.rsp.rdata = 128'({8'h00, s.depth, s.holdMs});
            `BEPD_IDX_PANEL_LOCK:
               next_s.rsp.rdata = 128'(s.lock);
            default:
               next_s.rsp.error = 1'b1;
         endcase
      end

      // Process data assembly, one byte per clock after each pass
      code = s.slots[8*(`BEPD_SLOTS - 1 - int'(s.slotIdx[3:0])) +: 8];
      unique case (s.asmState)
         BEPD_ASM_IDLE:
         begin
            if (s.asmGo)
            begin
               next_s.asmState = BEPD_ASM_SLOT;
               next_s.slotIdx  = 5'h00;
               next_s.bytePtr  = 6'h00;
               next_s.cursor   = 16'h0000;
               next_s.shadow   = '0;
            end
         end
         BEPD_ASM_SLOT:
         begin
            // Slot one first, then upward; stop at the byte limit
            if (s.slotIdx == 5'(`BEPD_SLOTS) || s.remain == 8'hff)
               next_s.asmState = BEPD_ASM_DONE;
            else
            begin
               next_s.slotIdx  = s.slotIdx + 5'h01;
               next_s.isStream = (code <= `BEPD_CODE_STREAM_MAX);
               next_s.remain   = 8'h02;
               unique case (code)
                  `BEPD_CODE_FIRST_BLOCKED: next_s.word = firstBlocked;
                  `BEPD_CODE_FIRST_CLEAR:   next_s.word = firstClear;
                  `BEPD_CODE_LAST_BLOCKED:  next_s.word = lastBlocked;
                  `BEPD_CODE_LAST_CLEAR:    next_s.word = lastClear;
                  `BEPD_CODE_BLOCKED_TOTAL: next_s.word = blockedTotal;
                  `BEPD_CODE_CLEAR_TOTAL:
                     next_s.word = BEAM_COUNT - blockedTotal;
                  `BEPD_CODE_AREAS_LOW:     next_s.word = areaState[15:0];
                  `BEPD_CODE_AREAS_HIGH:    next_s.word = areaState[31:16];
                  `BEPD_CODE_OUTPUTS:       next_s.word = mappedOutputs;
                  `BEPD_CODE_STATUS:        next_s.word = statusWord;
                  default:
                  begin
                     next_s.word   = 16'h0000;
                     next_s.remain = {code[6:0], 1'b0};
                  end
               endcase
               if (code != `BEPD_CODE_NONE)
                  next_s.asmState = BEPD_ASM_BYTE;
            end
         end
         BEPD_ASM_BYTE:
         begin
            if (s.isStream)
            begin
               // Eight consecutive beams per byte, beam of lowest number in bit 0
               for (int j = 0; j < 8; j++)
               begin
                  idx = int'(s.cursor) + j;
                  byteVal[j] = (idx < BEAMS) ? s.held[idx] : 1'b0;
               end
               next_s.cursor = s.cursor + 16'h0008;
            end
            else
               byteVal = (s.remain == 8'h02) ? s.word[15:8] : s.word[7:0];
            next_s.shadow[8*(`BEPD_PD_BYTES - 1 - int'(s.bytePtr)) +: 8] = byteVal;
            next_s.remain  = s.remain - 8'h01;
            next_s.bytePtr = s.bytePtr + 6'h01;
            if (s.bytePtr == PD_LAST)
            begin
               next_s.remain   = 8'hff;   // Frame full, close it
               next_s.asmState = BEPD_ASM_SLOT;
            end
            else if (s.remain == 8'h01)
               next_s.asmState = BEPD_ASM_SLOT;
         end
         BEPD_ASM_DONE:
         begin
            next_s.pdData   = s.shadow;
            next_s.pdLength = s.bytePtr;
            next_s.pdUpdate = 1'b1;
            next_s.remain   = 8'h00;
            next_s.asmState = BEPD_ASM_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s        <= '0;
         s.slots  <= SLOT_RESET;
         s.depth  <= `BEPD_DEPTH_RESET;
         s.holdMs <= `BEPD_HOLD_RESET;
         s.lock   <= `BEPD_LOCK_RESET;
         s.asmState <= BEPD_ASM_IDLE;
      end
      else
         s <= next_s;
   end

   // Outputs straight from the state
   assign parRsp   = s.rsp;
   assign keyOut   = s.keyOut;
   assign pdData   = s.pdData;
   assign pdLength = s.pdLength;
   assign pdUpdate = s.pdUpdate;

endmodule

`default_nettype wire

/* rtl/bepd_beam_filter.sv */
// One beam's consistency filter.
// Assumes pass pulses once per measurement cycle on the same clock.
`timescale 1ns/10ps
`default_nettype none

module bepd_beam_filter
   import bepd_pkg::*;
(
   input  wire logic       clock,    // System clock
   input  wire logic       rst_n,    // Synchronous reset, active low
   input  wire logic       pass,     // Measurement pass pulse
   input  wire logic       raw,      // Raw beam state, 1 = blocked
   input  wire logic [7:0] depth,    // Passes needed before a change
   output logic            filtered  // Filtered beam state
);

   typedef struct packed {
      logic [7:0] count;
      logic       state;
   } bepd_filter_state_type;

   bepd_filter_state_type s;
   bepd_filter_state_type next_s;

   // A differing state must persist for depth passes before it is taken
   always_comb
   begin
      next_s = s;
      if (pass)
      begin
         if (raw == s.state)
            next_s.count = 8'h00;
         else if (s.count + 8'h01 >= depth)
         begin
            next_s.state = raw;
            next_s.count = 8'h00;
         end
         else
            next_s.count = s.count + 8'h01;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

   assign filtered = s.state;

endmodule

`default_nettype wire

/* rtl/bepd_map.svh */
// Constants of the beam evaluation and process data block: parameter
// indices, field positions, reset values and timing figures.
// Assumes inclusion by bare name from the package and the design files.
`ifndef BEPD_MAP_SVH
`define BEPD_MAP_SVH

// ----------------------------------------------------------------------
// Parameter indices
// ----------------------------------------------------------------------
`define BEPD_IDX_CYCLE_TIME     8'h44
`define BEPD_IDX_SLOT_RECORD    8'h48
`define BEPD_IDX_EXTENDED       8'h4a
`define BEPD_IDX_PANEL_LOCK     8'h4e

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BEPD_SLOT_ONE_POS       120
`define BEPD_SLOT_SIXTEEN_POS   0
`define BEPD_DEPTH_POS          16
`define BEPD_HOLD_POS           0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BEPD_SLOT_ONE_RESET     8'hca
`define BEPD_SLOT_OTHER_RESET   8'h00
`define BEPD_DEPTH_RESET        8'h01
`define BEPD_HOLD_RESET         16'h0000
`define BEPD_LOCK_RESET         1'b0

// ----------------------------------------------------------------------
// Slot codes
// ----------------------------------------------------------------------
`define BEPD_CODE_NONE          8'h00
`define BEPD_CODE_STREAM_MAX    8'h6f
`define BEPD_CODE_FIRST_BLOCKED 8'hc8
`define BEPD_CODE_FIRST_CLEAR   8'hc9
`define BEPD_CODE_LAST_BLOCKED  8'hca
`define BEPD_CODE_LAST_CLEAR    8'hcb
`define BEPD_CODE_BLOCKED_TOTAL 8'hcc
`define BEPD_CODE_CLEAR_TOTAL   8'hcd
`define BEPD_CODE_AREAS_LOW     8'hd0
`define BEPD_CODE_AREAS_HIGH    8'hd1
`define BEPD_CODE_OUTPUTS       8'hd2
`define BEPD_CODE_STATUS        8'hd4

// ----------------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------------
`define BEPD_CLOCK_MHZ          50
`define BEPD_CYCLE_TIME_US      1000
`define BEPD_MS_US              1000
`define BEPD_PD_BYTES           32
`define BEPD_SLOTS              16
`define BEPD_BEAMS_PER_CASCADE  16

`endif

/* rtl/bepd_pkg.sv */
// Types shared by the beam evaluation and process data block.
// Assumes the constants header sits beside it.
`include "bepd_map.svh"

package bepd_pkg;

   // Parameter request from the serial link master
   typedef struct packed {
      logic         write;   // Write the record at index
      logic         read;    // Read the record at index
      logic [7:0]   index;   // Parameter index
      logic [127:0] data;    // Whole record, low aligned
   } bepd_par_cmd_type;

   // Parameter answer
   typedef struct packed {
      logic         ack;     // One-cycle answer
      logic         error;   // Unknown index or read-only write
      logic [127:0] rdata;   // Read record, low aligned
   } bepd_par_rsp_type;

   // Process data assembly states
   typedef enum logic [1:0] {
      BEPD_ASM_IDLE = 2'b00,
      BEPD_ASM_SLOT = 2'b01,
      BEPD_ASM_BYTE = 2'b11,
      BEPD_ASM_DONE = 2'b10
   } bepd_asm_type;

endpackage

/* tb/bepd_beam_eval_checker.sv */
// Assertions on the ports of the beam evaluation block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module bepd_beam_eval_checker
   import bepd_pkg::*;
#(
   parameter int KEYS = 4
)
(
   input wire logic             clock,    // System clock
   input wire logic             rst_n,    // Reset, active low
   input wire logic [KEYS-1:0]  keyRaw,   // Keys from pins
   input wire bepd_par_cmd_type parCmd,   // Parameter request
   input wire bepd_par_rsp_type parRsp,   // Parameter answer
   input wire logic [KEYS-1:0]  keyOut,   // Keys after lock
   input wire logic [255:0]     pdData,   // Process data
   input wire logic [5:0]       pdLength, // Valid bytes
   input wire logic             pdUpdate  // Update pulse
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic       req;     // Any request this cycle
   logic       known;   // Index is mapped
   logic       lockQ;   // Lock as last written
   logic [2:0] lockAge; // Cycles since lock write or reset
   assign req   = parCmd.write | parCmd.read;
   assign known = parCmd.index inside {8'h44, 8'h48, 8'h4a, 8'h4e};

   // Age saturates so key checks wait out the sync latency
   always_ff @(posedge clock)
   begin
      if (!rst_n || (parCmd.write && parCmd.index == 8'h4e))
      begin
         lockQ   <= rst_n ? parCmd.data[0] : 1'b0;
         lockAge <= 3'h0;
      end
      else if (lockAge != 3'h7)
         lockAge <= lockAge + 3'h1;
   end

   property p_ack_next; req |-> ##1 parRsp.ack; endproperty
   a_ack_next: assert property (p_ack_next) else $error("no answer");
   property p_ack_idle; !req |=> !parRsp.ack && !parRsp.error; endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("stray answer");
   property p_err_ro; parCmd.write && parCmd.index == 8'h44 |=> parRsp.error; endproperty
   a_err_ro: assert property (p_err_ro) else $error("cycle time written");
   property p_err_unk; req && !known |=> parRsp.error; endproperty
   a_err_unk: assert property (p_err_unk) else $error("unknown index taken");
   property p_lock; lockAge == 3'h7 && lockQ |-> keyOut == '0; endproperty
   a_lock: assert property (p_lock) else $error("key passed when locked");
   property p_unlock; lockAge == 3'h7 && !lockQ |-> keyOut == $past(keyRaw, 3); endproperty
   a_unlock: assert property (p_unlock) else $error("key lost when open");
   property p_pd_len; pdUpdate |-> pdLength <= 6'd32; endproperty
   a_pd_len: assert property (p_pd_len) else $error("process data too long");
   property p_pd_hold; !pdUpdate |-> $stable(pdData) && $stable(pdLength); endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("data moved");
   property p_pd_gap; pdUpdate |=> !pdUpdate [*8]; endproperty
   a_pd_gap: assert property (p_pd_gap) else $error("updates too close");
   property p_rd_idle; !parRsp.ack |-> parRsp.rdata == '0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without answer");

   c_full: cover property (pdUpdate && pdLength == 6'd32);
   c_lock: cover property (lockAge == 3'h7 && lockQ);
   c_err:  cover property (parRsp.error);
endmodule

bind bepd_beam_eval bepd_beam_eval_checker #(.KEYS(KEYS)) u_chk (.clock(clock),
   .rst_n(rst_n), .keyRaw(keyRaw), .parCmd(parCmd), .parRsp(parRsp), .keyOut(keyOut),
   .pdData(pdData), .pdLength(pdLength), .pdUpdate(pdUpdate));

`default_nettype wire

/* tb/bepd_beam_eval_tb.sv */
// Self-checking bench of the beam evaluation block.
// Assumes shortened pass and millisecond counts.
`timescale 1ns/10ps
`default_nettype none

module bepd_beam_eval_tb
   import bepd_pkg::*;
;
   localparam int BEAMS = 32;
   logic             clock;
   logic             rst_n;
   logic [BEAMS-1:0] beamRaw;
   logic [31:0]      areaState;
   logic [15:0]      mappedOutputs;
   logic [15:0]      statusWord;
   logic [3:0]       keyRaw;
   bepd_par_cmd_type parCmd;
   bepd_par_rsp_type parRsp;
   logic [3:0]       keyOut;
   logic [255:0]     pdData;
   logic [5:0]       pdLength;
   logic             pdUpdate;
   logic [127:0]     rd;
   logic             ok;
   int               fails;
   int               num_checks;
   int               i;
   int               cnt;
   integer           seed = 32'h1903;
   logic [127:0]     recs [5] = '{{8'hca, 120'h0},
      {8'd200, 8'd201, 8'd203, 8'd204, 8'd205, 8'd208, 8'd209, 8'd210, 8'd212, 56'h0},
      {8'd1, 8'd0, 8'd202, 8'd2, 96'h0}, {8'd17, 8'd204, 112'h0},
      {8'd200, 8'd201, 8'd202, 8'd203, 96'h0}};

   bepd_beam_eval #(.BEAMS(BEAMS), .KEYS(4), .CYCLE_CLKS(100), .MS_CLKS(10)) dut (
      .clock(clock), .rst_n(rst_n), .beamRaw(beamRaw), .areaState(areaState),
      .mappedOutputs(mappedOutputs), .statusWord(statusWord), .keyRaw(keyRaw),
      .parCmd(parCmd), .parRsp(parRsp), .keyOut(keyOut), .pdData(pdData),
      .pdLength(pdLength), .pdUpdate(pdUpdate));
   bepd_link_master link (.clock(clock), .parCmd(parCmd), .parRsp(parRsp));

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic check(input string what, input logic [255:0] e, input logic [255:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("unexpected %s: expected %h, seen %h", what, e, g);
         fails++;
      end
   endtask

   task automatic par(input logic wr, input logic [7:0] idx, input logic [127:0] dat);
      link.xfer(wr, idx, dat, rd, ok);
   endtask

   // Bounded wait, so a silent design ends as a mismatch
   task automatic wait_upd(input int n);
      int t;
      repeat (n)
      begin
         t = 0;
         do begin @(negedge clock); t++; end while (pdUpdate !== 1'b1 && t < 400);
         if (t >= 400) check("pdUpdate", 1, pdUpdate);
      end
   endtask

   // Expected bytes: slot one first, stream cursor shared, cut at 32
   task automatic expect_pd(input logic [127:0] r);
      int s, b, j, cur, n, fb, fc, lb, lc, tb;
      logic [7:0] c, by;
      logic [15:0] w;
      logic [255:0] d;
      {cur, n, fb, fc, lb, lc, tb} = '0;
      d = '0;
      for (j = 0; j < BEAMS; j++)
         if (beamRaw[j]) begin if (fb == 0) fb = j + 1; lb = j + 1; tb++; end
         else begin if (fc == 0) fc = j + 1; lc = j + 1; end
      for (s = 0; s < 16; s++)
      begin
         c = r[127-8*s -: 8];
         if (c >= 8'd1 && c <= 8'd111)
            for (b = 0; b < 2 * c; b++)
            begin
               for (j = 0; j < 8; j++) by[j] = (cur + j < BEAMS) ? beamRaw[cur+j] : 1'b0;
               cur += 8;
               if (n < 32) d[255-8*n -: 8] = by;
               n++;
            end
         else if (c != 8'd0)
         begin
            case (c)
               8'd200: w = 16'(fb);
               8'd201: w = 16'(fc);
               8'd202: w = 16'(lb);
               8'd203: w = 16'(lc);
               8'd204: w = 16'(tb);
               8'd205: w = 16'(BEAMS - tb);
               8'd208: w = areaState[15:0];
               8'd209: w = areaState[31:16];
               8'd210: w = mappedOutputs;
               default: w = statusWord;
            endcase
            for (b = 0; b < 2; b++)
            begin
               if (n < 32) d[255-8*n -: 8] = b ? w[7:0] : w[15:8];
               n++;
            end
         end
      end
      check("pdData", d, pdData);
      check("pdLength", (n > 32) ? 6'd32 : 6'(n), pdLength);
   endtask

   task close_out;
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog: far beyond the expected few thousand cycles
   initial
   begin
      #(20000 * 20);
      check("watchdog", 0, 1);
      close_out();
   end

   initial
   begin
      {rst_n, beamRaw, areaState, mappedOutputs, statusWord, keyRaw} = '0;
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      par(0, 8'h48, '0); check("slot record", {8'hca, 120'h0}, rd);
      par(0, 8'h4a, '0); check("extended", 128'h10000, rd);
      par(0, 8'h4e, '0); check("lock", 0, rd);
      par(0, 8'h44, '0); check("cycle time", 128'd1000, rd);
      par(1, 8'h44, 128'h5); check("read-only write", 0, ok);
      par(0, 8'h10, '0); check("unknown index", 0, ok);
      par(1, 8'h48, {8'hff, 8'd112, 8'd206, 8'd212, 96'h0});
      par(0, 8'h48, '0); check("bad codes", {8'hca, 16'h0, 8'd212, 96'h0}, rd);
      // Each record over one beam image: random, all-clear for the second, all-blocked for the fifth
      for (i = 0; i < 5; i++)
      begin
         beamRaw = (i == 1) ? '0 : (i == 4) ? '1 : BEAMS'($random(seed));
         {areaState, mappedOutputs, statusWord} = {$random(seed), $random(seed)};
         par(1, 8'h48, recs[i]);
         wait_upd(3);
         expect_pd(recs[i]);
      end
      par(1, 8'h4a, 128'h30000);
      par(1, 8'h4a, 128'h0);
      par(0, 8'h4a, '0); check("depth kept", 128'h30000, rd);
      par(1, 8'h48, {8'd204, 120'h0});
      beamRaw = '0;
      wait_upd(3);
      beamRaw = 32'h0000_0f00;
      for (i = 1; i <= 3; i++)
      begin
         wait_upd(1);
         check("blocked total", (i == 3) ? 16'd4 : 16'd0, pdData[255:240]);
      end
      // One-pass blockage must outlive its pass inside the hold window
      par(1, 8'h4a, 128'h1_0014);
      beamRaw = '0;
      wait_upd(4);
      beamRaw = 32'h1;
      wait_upd(1);
      beamRaw = '0;
      cnt = 0;
      repeat (6) begin wait_upd(1); if (pdData[255:240] === 16'd1) cnt++; end
      check("held passes", 1, cnt >= 2);
      par(1, 8'h4e, 128'h1);
      keyRaw = 4'hf;
      repeat (5) @(negedge clock);
      check("locked keys", 0, keyOut);
      par(1, 8'h4e, 128'h0);
      keyRaw = 4'($random(seed));
      repeat (5) @(negedge clock);
      check("open keys", keyRaw, keyOut);
      rst_n = 1'b0;
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      par(0, 8'h48, '0); check("slot record", {8'hca, 120'h0}, rd);
      close_out();
   end
endmodule

`default_nettype wire

/* tb/bepd_link_master.sv */
// Serial link master model: one-strobe parameter requests.
// Assumes the answer comes one edge after the request is taken.
`timescale 1ns/10ps
`default_nettype none

module bepd_link_master
   import bepd_pkg::*;
(
   input  wire logic             clock,  // System clock
   output var bepd_par_cmd_type  parCmd, // Parameter request
   input  wire bepd_par_rsp_type parRsp  // Parameter answer
);
   initial parCmd = '0;

   // Idle fields show inverted values so stale data is never trusted
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [127:0] dat,
                       output logic [127:0] rd, output logic ok);
      @(negedge clock);
      parCmd = '{write: wr, read: !wr, index: idx, data: dat};
      @(negedge clock);
      // The answer stands for this one cycle only, so take it now
      rd = parRsp.rdata;
      ok = parRsp.ack & !parRsp.error;
      parCmd = '{write: 1'b0, read: 1'b0, index: ~idx, data: ~dat};
   endtask
endmodule

`default_nettype wire
